//--- rtl/isodio_top.sv
/*
 isodio_top: isolated digital i/o port, three byte registers.
 assumes: host strobes are one-cycle, synchronous to REF_CLK_IN;
 input lines are already synchronous.
*/
`timescale 1ns/100ps
`default_nettype none
`include "isodio_regs.svh"

module isodio_top (
   // clock and reset
   input  wire logic                    REF_CLK_IN,
   input  wire logic                    RST_IN,
   // host register port
   input  wire isodio_pkg::isodio_req_t HOST_REQ_IN,
   output logic [7:0]                   HOST_RDATA_OUT,
   // field lines
   input  wire logic [7:0]              ISO_INPUT_LINE_IN,
   output logic [7:0]                   ISO_OUTPUT_LINE_OUT,
   output logic [7:0]                   ISO_OUTPUT_OE_OUT,
   // interrupt request, never raised
   output logic                         HOST_IRQ_OUT
);

   logic [7:0]              out_latch_q;
   logic [7:0]              rdata_q;
   logic                    wr_out;
   logic                    wr_mode;
   logic                    rd_any;
   logic                    port_reset;
   isodio_pkg::isodio_dir_t out_dir_q;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   assign wr_out  = HOST_REQ_IN.wr & (HOST_REQ_IN.addr == `ISODIO_OFS_OUT);
   assign wr_mode = HOST_REQ_IN.wr & (HOST_REQ_IN.addr == `ISODIO_OFS_MODE);
   assign rd_any  = HOST_REQ_IN.rd;

   // ----------------------------------------------------------------
   // mode word
   // ----------------------------------------------------------------
   isodio_mode u_mode (
      .clk_in         (REF_CLK_IN),
      .rst_in         (RST_IN),
      .mode_wr_in     (wr_mode),
      .mode_data_in   (HOST_REQ_IN.wdata),
      .dir_out        (out_dir_q),
      .port_reset_out (port_reset)
   );

   // ----------------------------------------------------------------
   // output latch
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN || port_reset) begin
         out_latch_q <= `ISODIO_OUT_RST;
      end else if (wr_out) begin
         out_latch_q <= HOST_REQ_IN.wdata;
      end
   end

   // bit n drives line n, only when port is output
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_line
         assign ISO_OUTPUT_LINE_OUT[g] = out_latch_q[g] &
            (out_dir_q == isodio_pkg::ISODIO_DIR_OUT);
         assign ISO_OUTPUT_OE_OUT[g] =
            (out_dir_q == isodio_pkg::ISODIO_DIR_OUT);

         // per-bit write and read paths
         a_line_bit: assert property (
            @(posedge REF_CLK_IN) disable iff (RST_IN)
            wr_out && HOST_REQ_IN.wdata[g] &&
            out_dir_q == isodio_pkg::ISODIO_DIR_OUT
            |=> ISO_OUTPUT_LINE_OUT[g]
         )
         else $error("output line bit not driven high");

         a_in_bit: assert property (
            @(posedge REF_CLK_IN) disable iff (RST_IN)
            rd_any && HOST_REQ_IN.addr == `ISODIO_OFS_IN &&
            ISO_INPUT_LINE_IN[g]
            |=> HOST_RDATA_OUT[g]
         )
         else $error("input bit high not read as one");
      end
   endgenerate

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_IN) begin
      if (RST_IN) begin
         rdata_q <= `ISODIO_RD_IDLE;
      end else if (rd_any) begin
         unique case (HOST_REQ_IN.addr)
            `ISODIO_OFS_OUT: rdata_q <= ISO_OUTPUT_LINE_OUT;
            `ISODIO_OFS_IN: begin
               rdata_q <= ISO_INPUT_LINE_IN;
            end
            default:         rdata_q <= `ISODIO_RD_IDLE;
         endcase
      end
   end

   assign HOST_RDATA_OUT = rdata_q;
   assign HOST_IRQ_OUT   = 1'b0;

   // ----------------------------------------------------------------
   // assertions: register writes
   // ----------------------------------------------------------------
   a_out_write: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      wr_out |=> out_latch_q == $past(HOST_REQ_IN.wdata)
   )
   else $error("output latch did not take write");

   a_wr_ignored: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      HOST_REQ_IN.wr && HOST_REQ_IN.addr != `ISODIO_OFS_OUT &&
      HOST_REQ_IN.addr != `ISODIO_OFS_MODE
      |=> $stable(out_latch_q) && $stable(out_dir_q)
   )
   else $error("write to read-only offset changed state");

   a_latch_hold: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      !wr_out && !wr_mode |=> $stable(out_latch_q)
   )
   else $error("output latch changed without write");

   a_mode_clear: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      wr_mode |=> out_latch_q == `ISODIO_OUT_RST
   )
   else $error("mode write did not clear latch");

   a_mode_dir: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      wr_mode && HOST_REQ_IN.wdata == `ISODIO_MW_SETUP
      |=> out_dir_q == isodio_pkg::ISODIO_DIR_OUT
   )
   else $error("setup word did not set output direction");

   a_mode_dontcare: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      wr_mode && HOST_REQ_IN.wdata[`ISODIO_MW_BIT7] &&
      HOST_REQ_IN.wdata[`ISODIO_MW_BIT1] &&
      !HOST_REQ_IN.wdata[`ISODIO_MW_BIT2] &&
      HOST_REQ_IN.wdata[`ISODIO_MW_HI6_4:`ISODIO_MW_LO6_4] == 3'h0
      |=> out_dir_q == isodio_pkg::ISODIO_DIR_OUT
   )
   else $error("ignored mode bits changed direction");

   a_bad_mode: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      wr_mode && (!HOST_REQ_IN.wdata[`ISODIO_MW_BIT7] ||
      !HOST_REQ_IN.wdata[`ISODIO_MW_BIT1] ||
      HOST_REQ_IN.wdata[`ISODIO_MW_BIT2] ||
      HOST_REQ_IN.wdata[`ISODIO_MW_HI6_4:`ISODIO_MW_LO6_4] != 3'h0)
      |=> out_dir_q == isodio_pkg::ISODIO_DIR_IN
   )
   else $error("illegal mode word accepted");

   a_dir_hold: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      !wr_mode |=> $stable(out_dir_q)
   )
   else $error("direction changed without mode write");

   // ----------------------------------------------------------------
   // assertions: read path
   // ----------------------------------------------------------------
   a_out_read: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      rd_any && HOST_REQ_IN.addr == `ISODIO_OFS_OUT
      |=> HOST_RDATA_OUT == $past(ISO_OUTPUT_LINE_OUT)
   )
   else $error("output read mismatch");

   a_out_rd_input: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      rd_any && HOST_REQ_IN.addr == `ISODIO_OFS_OUT &&
      out_dir_q == isodio_pkg::ISODIO_DIR_IN
      |=> HOST_RDATA_OUT == 8'h00
   )
   else $error("output read not low while input direction");

   a_in_read: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      rd_any && HOST_REQ_IN.addr == `ISODIO_OFS_IN
      |=> HOST_RDATA_OUT == $past(ISO_INPUT_LINE_IN)
   )
   else $error("input read mismatch");

   a_in_zero: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      rd_any && HOST_REQ_IN.addr == `ISODIO_OFS_IN &&
      ISO_INPUT_LINE_IN == 8'h00
      |=> HOST_RDATA_OUT == 8'h00
   )
   else $error("idle inputs not low");

   a_rd_unmapped: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      rd_any && (HOST_REQ_IN.addr == `ISODIO_OFS_MODE ||
      HOST_REQ_IN.addr == 2'h2)
      |=> HOST_RDATA_OUT == `ISODIO_RD_IDLE
   )
   else $error("unmapped or write-only read not zero");

   a_rd_hold: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      !rd_any |=> $stable(HOST_RDATA_OUT)
   )
   else $error("read data changed without read");

   // ----------------------------------------------------------------
   // assertions: line drive
   // ----------------------------------------------------------------
   a_line_drive: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      out_dir_q == isodio_pkg::ISODIO_DIR_OUT
      |-> ISO_OUTPUT_LINE_OUT == out_latch_q
   )
   else $error("output line not following latch");

   a_lines_low: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      out_dir_q == isodio_pkg::ISODIO_DIR_IN
      |-> ISO_OUTPUT_LINE_OUT == 8'h00 && ISO_OUTPUT_OE_OUT == 8'h00
   )
   else $error("outputs active while input direction");

   a_oe_all: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      ISO_OUTPUT_OE_OUT ==
      {8{out_dir_q == isodio_pkg::ISODIO_DIR_OUT}}
   )
   else $error("output enables not uniform");

   a_oe_rise: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      $rose(ISO_OUTPUT_OE_OUT[0]) |-> $past(wr_mode)
   )
   else $error("output enable rose without mode write");

   a_line_change: assert property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      ISO_OUTPUT_LINE_OUT != $past(ISO_OUTPUT_LINE_OUT)
      |-> $past(wr_out) || $past(wr_mode) || $past(RST_IN)
   )
   else $error("output lines changed without cause");

   // ----------------------------------------------------------------
   // assertions: reset and interrupt
   // ----------------------------------------------------------------
   a_rst_dir: assert property (
      @(posedge REF_CLK_IN)
      RST_IN |=> out_dir_q == isodio_pkg::ISODIO_DIR_IN &&
      out_latch_q == `ISODIO_OUT_RST
   )
   else $error("reset state wrong");

   a_rst_rdata: assert property (
      @(posedge REF_CLK_IN)
      RST_IN |=> HOST_RDATA_OUT == `ISODIO_RD_IDLE
   )
   else $error("read data not idle after reset");

   a_no_irq: assert property (
      @(posedge REF_CLK_IN)
      HOST_IRQ_OUT == 1'b0
   )
   else $error("interrupt raised");

   // ----------------------------------------------------------------
   // covers
   // ----------------------------------------------------------------
   c_setup: cover property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      wr_mode && HOST_REQ_IN.wdata == `ISODIO_MW_SETUP
   );

   c_write_out: cover property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      out_dir_q == isodio_pkg::ISODIO_DIR_OUT && wr_out
      ##1 ISO_OUTPUT_LINE_OUT != 8'h00
   );

   c_read_in: cover property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      rd_any && HOST_REQ_IN.addr == `ISODIO_OFS_IN &&
      ISO_INPUT_LINE_IN != 8'h00
   );

   c_bad_mode: cover property (
      @(posedge REF_CLK_IN) disable iff (RST_IN)
      wr_mode && !HOST_REQ_IN.wdata[`ISODIO_MW_BIT7]
   );

   c_mid_reset: cover property (
      @(posedge REF_CLK_IN)
      out_dir_q == isodio_pkg::ISODIO_DIR_OUT && RST_IN
   );

endmodule
`default_nettype wire

//--- rtl/isodio_regs.svh
/*
 isodio_regs.svh: offsets, field positions and reset values for the
 isolated digital i/o port block.
 assumes: included by its bare name from rtl files.
*/
`ifndef ISODIO_REGS_SVH
`define ISODIO_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ISODIO_OFS_OUT      2'h0
`define ISODIO_OFS_IN       2'h1
`define ISODIO_OFS_MODE     2'h3

// ----------------------------------------------------------------
// mode word fields
// ----------------------------------------------------------------
`define ISODIO_MW_BIT7      7
`define ISODIO_MW_BIT1      1
`define ISODIO_MW_BIT2      2
`define ISODIO_MW_HI6_4     6
`define ISODIO_MW_LO6_4     4
`define ISODIO_MW_SETUP     8'h82

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ISODIO_OUT_RST      8'h00
`define ISODIO_RD_IDLE      8'h00

`endif

//--- rtl/isodio_pkg.sv
/*
 isodio_pkg: types shared by the isolated digital i/o port block.
 assumes: nothing beyond a systemverilog compiler.
*/
package isodio_pkg;

   // host register access, one byte wide
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [1:0] addr;
      logic [7:0] wdata;
   } isodio_req_t;

   // port direction state
   typedef enum logic [0:0] {
      ISODIO_DIR_IN  = 1'b0,
      ISODIO_DIR_OUT = 1'b1
   } isodio_dir_t;

endpackage

//--- rtl/isodio_mode.sv
/*
 isodio_mode: decodes the port mode word and keeps the direction state.
 assumes: write strobe is one cycle, synchronous to the clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "isodio_regs.svh"

module isodio_mode (
   // clock and reset
   input  wire logic               clk_in,
   input  wire logic               rst_in,
   // mode word write
   input  wire logic               mode_wr_in,
   input  wire logic [7:0]         mode_data_in,
   // state
   output isodio_pkg::isodio_dir_t dir_out,
   output logic                    port_reset_out
);

   logic                    valid_word;
   isodio_pkg::isodio_dir_t dir_q;

   // ----------------------------------------------------------------
   // mode word check
   // ----------------------------------------------------------------
   // bits 3 and 0 ignored
   always_comb begin
      valid_word = mode_data_in[`ISODIO_MW_BIT7] &
                   mode_data_in[`ISODIO_MW_BIT1] &
                   ~mode_data_in[`ISODIO_MW_BIT2] &
                   ~(|mode_data_in[`ISODIO_MW_HI6_4:`ISODIO_MW_LO6_4]);
   end

   // every mode write resets the ports
   assign port_reset_out = mode_wr_in;

   // ----------------------------------------------------------------
   // direction state
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         dir_q <= isodio_pkg::ISODIO_DIR_IN;
      end else if (mode_wr_in) begin
         dir_q <= valid_word ? isodio_pkg::ISODIO_DIR_OUT
                             : isodio_pkg::ISODIO_DIR_IN;
      end
   end

   assign dir_out = dir_q;

endmodule
`default_nettype wire

//--- verif/isodio_field_model.sv
/*
 isodio_field_model: field wiring in front of the isolated input lines.
 assumes: the bench sets which isolators are wired and their levels.
*/
`timescale 1ns/100ps
`default_nettype none
module isodio_field_model (
   // wiring state
   input  wire logic [7:0] conn_mask_in,
   input  wire logic [7:0] level_in,
   // sensed lines
   output logic      [7:0] line_out
);
   // open isolator senses low
   assign line_out = level_in & conn_mask_in;
endmodule
`default_nettype wire

//--- verif/tb_top.sv
/*
 tb_top: self-checking bench for the isolated digital i/o port.
 assumes: isodio_pkg, isodio_top and isodio_field_model compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // ------------------------------------------------
   // signals
   // ------------------------------------------------
   logic                    clk = 1'b0;
   logic                    rst = 1'b1;
   isodio_pkg::isodio_req_t req = '0;
   logic [7:0]              conn = 8'h00;
   logic [7:0]              lvl = 8'h00;
   logic [7:0]              rdata, in_line, out_line, out_oe;
   logic                    irq;
   int                      mismatches = 0;
   int                      total_checks = 0;

   always #25 clk = ~clk;

   isodio_top i_isodio_top (
      .REF_CLK_IN          (clk),
      .RST_IN              (rst),
      .HOST_REQ_IN         (req),
      .HOST_RDATA_OUT      (rdata),
      .ISO_INPUT_LINE_IN   (in_line),
      .ISO_OUTPUT_LINE_OUT (out_line),
      .ISO_OUTPUT_OE_OUT   (out_oe),
      .HOST_IRQ_OUT        (irq)
   );
   isodio_field_model i_isodio_field_model (
      .conn_mask_in (conn),
      .level_in     (lvl),
      .line_out     (in_line)
   );
   // ------------------------------------------------
   // shared tasks
   // ------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic rd, input logic [1:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      #1;
      req = '{rd: rd, wr: ~rd, addr: a, wdata: d};
      @(posedge clk);
      #1;
      req = '0;
      chk("irq", 8'h00, {7'h00, irq});
   endtask
   task automatic rd_chk(input string what, input logic [1:0] a,
                         input logic [7:0] exp);
      bus(1'b1, a, 8'h00);
      chk(what, exp, rdata);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_setup;
      chk("oe", 8'h00, out_oe);
      chk("lines", 8'h00, out_line);
      bus(1'b0, 2'h3, 8'h8b);
      chk("oe", 8'hff, out_oe);
      bus(1'b0, 2'h3, 8'h82);
      chk("lines", 8'h00, out_line);
   endtask
   task automatic t_output;
      for (int n = 0; n < 8; n++) begin
         bus(1'b0, 2'h0, 8'h01 << n);
         chk("lines", 8'h01 << n, out_line);
         rd_chk("out_rd", 2'h0, 8'h01 << n);
      end
   endtask
   task automatic t_input;
      conn = 8'hf0;
      lvl = 8'hff;
      rd_chk("in_rd", 2'h1, 8'hf0);
      conn = 8'hff;
      lvl = 8'h5a;
      bus(1'b0, 2'h1, 8'hff);
      rd_chk("in_rd", 2'h1, 8'h5a);
      lvl = 8'ha5;
      rd_chk("in_rd", 2'h1, 8'ha5);
   endtask
   task automatic t_mode;
      logic [7:0] bad [4] = '{8'h80, 8'h86, 8'hc2, 8'h02};
      bus(1'b0, 2'h0, 8'ha5);
      chk("lines", 8'ha5, out_line);
      bus(1'b0, 2'h3, 8'h82);
      chk("lines", 8'h00, out_line);
      rd_chk("out_rd", 2'h0, 8'h00);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 2'h0, 8'h3c);
         bus(1'b0, 2'h3, bad[i]);
         chk("oe", 8'h00, out_oe);
         chk("lines", 8'h00, out_line);
         rd_chk("out_rd", 2'h0, 8'h00);
         bus(1'b0, 2'h3, 8'h82);
         chk("oe", 8'hff, out_oe);
      end
   endtask
   task automatic t_unmapped;
      bus(1'b0, 2'h2, 8'hff);
      rd_chk("rd2", 2'h2, 8'h00);
      rd_chk("rd3", 2'h3, 8'h00);
      chk("oe", 8'hff, out_oe);
   endtask
   task automatic t_reset;
      bus(1'b0, 2'h0, 8'h5a);
      chk("lines", 8'h5a, out_line);
      rd_chk("out_rd", 2'h0, 8'h5a);
      rst = 1'b1;
      @(posedge clk);
      #1;
      rst = 1'b0;
      chk("oe", 8'h00, out_oe);
      chk("lines", 8'h00, out_line);
      bus(1'b0, 2'h3, 8'h82);
      chk("oe", 8'hff, out_oe);
      rd_chk("out_rd", 2'h0, 8'h00);
   endtask
   // ------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      t_setup();
      t_output();
      t_input();
      t_mode();
      t_unmapped();
      t_reset();
      test_done();
   end
   initial begin
      #200000;
      mismatches++;
      test_done();
   end
endmodule
`default_nettype wire
